// file: rtl/motor_phase_event_control.sv
// Overview of operation
// RL1 - sensor type 00: bit 7 overflow flag
// RL2 - other sensor types: bit 7 tacho error
// RL3 - sensor type 00: bit 6 hardware Z select
// RL4 - speed sensors: bit 6 encoder A leads B
// RL5 - bit 5 selects simulated zero crossing
// RL6 - autoswitch: bit 4 selects simulated commutation
// RL7 - Z sampled at off end or fast
// RL8 - fast sampling forces zero off time
// RL9 - bits 2:0 pick comparator reference
// RL10 - input select routes comparator, 11 encoder
// RL11 - channel bits apply at C or immediately
// RL12 - channel bit 0 off, 1 on
// RL13 - phase register written as whole byte
// RL14 - page bit steers register page
// RL15 - soft reset returns all block registers
// RL16 - current filter code+1 samples, quarter clock
// RL17 - current blanking after each PWM turn-on
// RL18 - D filter code+1 samples at sampling clock
// RL19 - sensor mode disables D filtering
// RL20 - D window blanks detection after C
// RL21 - direct channel write makes a C event
// RL22 - blanking counts two clocks per step
// RL23 - filters restart on miss, fire after run
//
// The APB register port and the register offsets are this design's own decisions.
module motor_phase_event_control import motor_phase_pkg::*; #(
  parameter int DWIN_STEP_TICKS = 4 // sampling ticks per D window code step
) (
  input wire logic pclk, // peripheral clock, 25 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic position_input_a, // rotor position pin a
  input wire logic position_input_b, // rotor position pin b
  input wire logic position_input_c, // rotor position pin c
  input wire logic zero_cross_pin, // back-emf comparator output
  input wire logic current_over_pin, // current comparator output
  input wire logic demag_pin, // demagnetisation comparator output
  input wire logic timer_overflow, // position timer overflow pulse
  input wire logic tacho_error, // tacho error pulse
  input wire logic hw_commutation, // hardware commutation pulse
  input wire logic sim_zero_cross, // simulated zero-crossing pulse
  input wire logic sim_commutation, // simulated commutation pulse
  input wire logic pwm_on_start, // pwm turn-on pulse
  input wire logic pwm_off_end, // end of pwm off time pulse
  input wire logic scf_tick, // sampling clock strobe
  output logic [5:0] channel_on_bits, // inverter switch enables
  output logic [1:0] comparator_input_select, // comparator input route
  output logic encoder_mode, // a and b to encoder, mux bypassed
  output logic [2:0] reference_threshold_select, // reference level code
  output logic external_reference_sel, // reference from external pin
  output logic force_zero_off_time, // minimum off time ignored
  output logic z_event, // zero-crossing event pulse
  output logic c_event, // commutation event pulse
  output logic d_event, // demagnetisation event pulse
  output logic current_limit_event // current limit event pulse
);
  if (DWIN_STEP_TICKS < 1 || DWIN_STEP_TICKS > 4096) begin : g_chk
    $error("DWIN_STEP_TICKS out of range");
  end

  // software registers
  logic [7:0] ctrl3_q; // third control register
  logic [7:0] phase_pre_q; // phase state preload
  logic [7:0] phase_act_q; // phase state in force
  logic [7:0] curfb_q; // current feedback control
  logic [7:0] dfilt_q; // d event filter control
  logic [5:0] mode_q; // sensor type, autoswitch, sensor, direct
  // bus answer
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // pin synchronisers, three stages
  logic [5:0] pin_s1_q; // first stage, read only by second
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  logic [5:0] pin_st_q; // accepted level
  // event and timing state
  logic enc_lead_q; // encoder a leads b
  logic a_prev_q; // previous accepted a level
  logic z_q;
  logic c_q;
  logic d_q;
  logic cl_q;
  logic d_hit_q; // filter level one cycle ago
  logic cl_hit_q;
  logic [1:0] quarter_q; // divides clock by four
  logic [4:0] blank_q; // current blanking countdown
  logic [15:0] dwin_q; // d window countdown, sampling ticks
  logic fast_q; // zero off time request

  sample_filter_if cur_f ();
  sample_filter_if dem_f ();
  // synchronised pin levels
  wire a_st = pin_st_q[0];
  wire b_st = pin_st_q[1];
  wire zc_st = pin_st_q[3];
  wire cur_st = pin_st_q[4];
  wire dem_st = pin_st_q[5];
  wire [5:0] pin_eq = ~(pin_s2_q ^ pin_s3_q);
  wire [5:0] pin_st_d = (pin_eq & pin_s3_q) | (~pin_eq & pin_st_q);
  // field views
  wire [1:0] sensor_type_select = mode_q[1:0];
  wire tes_pos = (sensor_type_select == TES_POSITION);
  wire page1 = curfb_q[CF_PAGE];
  wire sensor_mode = mode_q[MD_SENSOR];
  wire direct_acc = mode_q[MD_DIRECT];
  // apb decode
  wire acc = psel & penable;
  wire acc_first = acc & ~pready_q;
  wire hit_ctrl3 = (paddr == OFS_CTRL3);
  wire hit_phase = (paddr == OFS_PHASE);
  wire hit_curfb = (paddr == OFS_CURFB);
  // RL14 page steering
  wire hit_dfilt = (paddr == OFS_DFILT) & ~page1;
  wire hit_stat = (paddr == OFS_DFILT) & page1;
  wire hit_mode = (paddr == OFS_MODE);
  wire mapped = hit_ctrl3 | hit_phase | hit_curfb | hit_dfilt | hit_stat | hit_mode;
  // writes land on the edge where ready is seen high
  wire wr_byte = acc & pready_q & pwrite & pstrb[0] & mapped;
  wire wr_ctrl3 = wr_byte & hit_ctrl3;
  wire wr_phase = wr_byte & hit_phase;
  wire wr_curfb = wr_byte & hit_curfb;
  // RL15 soft reset request
  wire soft_rst = wr_curfb & pwdata[CF_SRST];
  // status word: own live state
  wire [7:0] status = {2'h0, (blank_q != 5'h0), (dwin_q != 16'h0), cl_q, d_q, c_q, z_q};
  // RL4 bit 6 view depends on sensor type
  wire bit6_rd = tes_pos ? ctrl3_q[C3_HZ] : enc_lead_q;
  wire [7:0] ctrl3_rd = {ctrl3_q[C3_FLAG], bit6_rd, ctrl3_q[5:0]};
  wire [7:0] rd_byte =
    hit_ctrl3 ? ctrl3_rd :
    hit_phase ? phase_pre_q :
    hit_curfb ? curfb_q :
    hit_dfilt ? dfilt_q :
    hit_stat ? status :
    hit_mode ? {2'h0, mode_q} : 8'h00;
  // RL1 overflow flag source
  // RL2 tacho flag source
  wire flag_set = tes_pos ? timer_overflow : tacho_error;
  wire flag_clr = wr_ctrl3 & ~pwdata[C3_FLAG];
  wire flag_d = flag_set | (ctrl3_q[C3_FLAG] & ~flag_clr); // set beats clear
  // RL3 hz writable only for sensor type 00
  wire hz_d = (wr_ctrl3 & tes_pos) ? pwdata[C3_HZ] : ctrl3_q[C3_HZ];
  wire [7:0] ctrl3_d = {flag_d, hz_d, wr_ctrl3 ? pwdata[5:0] : ctrl3_q[5:0]};
  // RL7 z sample strobe
  wire z_tick = ctrl3_q[C3_FAST] ? scf_tick : pwm_off_end;
  wire z_hw = z_tick & zc_st & (ctrl3_q[C3_HZ] | ~tes_pos);
  // RL5 simulated or detected zero crossing
  wire z_d = ctrl3_q[C3_SZ] ? sim_zero_cross : z_hw;
  // RL21 direct write is itself a commutation
  wire direct_wr = wr_phase & direct_acc;
  // RL6 commutation source in autoswitch mode
  wire c_src = (mode_q[MD_AUTOSW] & ctrl3_q[C3_SC]) ? sim_commutation : hw_commutation;
  wire c_d = c_src | direct_wr;
  // current path: quarter-clock strobe and blanking
  wire quarter_tick = (quarter_q == QUARTER_LAST);
  // RL22 two clocks per blanking step
  wire [4:0] blank_load = 5'(curfb_q[2:0] * BLANK_STEP_CYC);
  wire blanked = (blank_q != 5'h0);
  // d path: window length in sampling ticks
  wire [15:0] dwin_load = 16'((dfilt_q[3:0] + 16'h1) * DWIN_STEP_TICKS);
  wire dwin_open = (dwin_q == 16'h0);
  // current filter hookup
  // RL16 quarter clock, code+1 samples
  assign cur_f.tick = quarter_tick;
  // RL17 blanked comparator is no sample
  assign cur_f.sample = cur_st & ~blanked;
  assign cur_f.bypass = 1'b0;
  assign cur_f.clear = soft_rst;
  assign cur_f.need = {1'b0, curfb_q[5:3]};
  // d filter hookup
  // RL18 sampling clock, code+1 samples
  assign dem_f.tick = scf_tick;
  // RL20 detection held off in window
  assign dem_f.sample = dem_st & dwin_open;
  // RL19 sensor mode passes first sample
  assign dem_f.bypass = sensor_mode;
  assign dem_f.clear = soft_rst;
  assign dem_f.need = dfilt_q[7:4];
  consecutive_filter u_cur_filter (
    .clk (pclk),
    .rst_n (presetn),
    .f (cur_f)
  );

  consecutive_filter u_dem_filter (
    .clk (pclk),
    .rst_n (presetn),
    .f (dem_f)
  );

  // outputs from flip-flops; encoder mode and external reference decoded from them
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // RL12 bit set means switch on
  assign channel_on_bits = phase_act_q[5:0];
  // RL10 input route and encoder mode
  assign comparator_input_select = phase_act_q[7:6];
  assign encoder_mode = (phase_act_q[7:6] == INSEL_ENCODER);
  // RL9 reference code, 111 is external
  assign reference_threshold_select = ctrl3_q[2:0];
  assign external_reference_sel = (ctrl3_q[2:0] == VREF_EXTERNAL);
  assign force_zero_off_time = fast_q;
  assign z_event = z_q;
  assign c_event = c_q;
  assign d_event = d_q;
  assign current_limit_event = cl_q;

  // apb answer: one wait state, data captured on first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~mapped;
      prdata_q <= acc_first ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // pin synchronisers, change taken once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_s3_q <= 6'h00;
      pin_st_q <= 6'h00;
    end else begin
      pin_s1_q <= {demag_pin, current_over_pin, zero_cross_pin,
                   position_input_c, position_input_b, position_input_a};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_st_q <= pin_st_d;
    end
  end

  // control registers; soft reset returns them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_q <= CTRL3_RST;
      curfb_q <= CURFB_RST;
      dfilt_q <= DFILT_RST;
      mode_q <= MODE_RST;
    end else if (soft_rst) begin
      // RL15 block registers back to reset
      ctrl3_q <= CTRL3_RST;
      curfb_q <= CURFB_RST;
      dfilt_q <= DFILT_RST;
      mode_q <= MODE_RST;
    end else begin
      ctrl3_q <= ctrl3_d;
      // reset request bit never stays set
      if (wr_curfb) begin
        curfb_q <= {pwdata[7], 1'b0, pwdata[5:0]};
      end
      if (wr_byte && hit_dfilt) begin
        dfilt_q <= pwdata[7:0];
      end
      if (wr_byte && hit_mode) begin
        mode_q <= pwdata[5:0];
      end
    end
  end

  // phase state: preload and the copy in force
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_pre_q <= PHASE_RST;
      phase_act_q <= PHASE_RST;
    end else if (soft_rst) begin
      phase_pre_q <= PHASE_RST;
      phase_act_q <= PHASE_RST;
    end else begin
      // RL13 whole byte lands in preload
      if (wr_phase) begin
        phase_pre_q <= pwdata[7:0];
      end
      // RL11 direct takes at once, else at C
      if (direct_wr) begin
        phase_act_q <= pwdata[7:0];
      end else if (c_d) begin
        phase_act_q <= phase_pre_q;
      end
    end
  end

  // encoder relative phase, sampled on each edge of input a
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_q <= 1'b0;
      enc_lead_q <= 1'b0;
    end else begin
      a_prev_q <= a_st;
      // RL4 b low at a rise: a leads
      if (a_st != a_prev_q) begin
        enc_lead_q <= a_st ^ b_st;
      end
    end
  end

  // event pulses and the zero off time request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_q <= 1'b0;
      c_q <= 1'b0;
      d_q <= 1'b0;
      cl_q <= 1'b0;
      d_hit_q <= 1'b0;
      cl_hit_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      z_q <= z_d & ~soft_rst;
      c_q <= c_d & ~soft_rst;
      d_hit_q <= dem_f.hit;
      cl_hit_q <= cur_f.hit;
      // pulse once per qualified run, not every sample
      d_q <= dem_f.hit & ~d_hit_q;
      cl_q <= cur_f.hit & ~cl_hit_q;
      // RL8 fast sampling zeroes off time
      fast_q <= ctrl3_d[C3_FAST] & ~soft_rst;
    end
  end

  // quarter-clock divider for current sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quarter_q <= 2'h0;
    end else begin
      quarter_q <= quarter_q + 2'h1;
    end
  end

  // current blanking countdown, restarted at each pwm turn-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q <= 5'h00;
    end else if (soft_rst) begin
      blank_q <= 5'h00;
    end else if (pwm_on_start) begin
      // RL17 window starts at turn-on
      blank_q <= blank_load;
    end else if (blanked) begin
      blank_q <= blank_q - 5'h01;
    end
  end

  // d window countdown in sampling ticks, restarted at each C event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwin_q <= 16'h0000;
    end else if (soft_rst) begin
      dwin_q <= 16'h0000;
    end else if (c_d) begin
      // RL20 window opens at C
      dwin_q <= dwin_load;
    end else if (scf_tick && !dwin_open) begin
      dwin_q <= dwin_q - 16'h0001;
    end
  end
endmodule

// file: rtl/motor_phase_pkg.sv
package motor_phase_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL3 = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_CURFB = 8'h08;
  localparam logic [7:0] OFS_DFILT = 8'h0c; // page 0: d filter, page 1: status
  localparam logic [7:0] OFS_MODE = 8'h10;
  // reset values
  localparam logic [7:0] CTRL3_RST = 8'h00;
  localparam logic [7:0] PHASE_RST = 8'h00;
  localparam logic [7:0] CURFB_RST = 8'h00;
  localparam logic [7:0] DFILT_RST = 8'h0f;
  localparam logic [5:0] MODE_RST = 6'h00;
  // third control register fields
  localparam int C3_FLAG = 7;
  localparam int C3_HZ = 6;
  localparam int C3_SZ = 5;
  localparam int C3_SC = 4;
  localparam int C3_FAST = 3;
  localparam logic [2:0] VREF_EXTERNAL = 3'h7;
  // phase state fields
  localparam logic [1:0] INSEL_ENCODER = 2'h3;
  // current feedback fields
  localparam int CF_PAGE = 7;
  localparam int CF_SRST = 6;
  // mode register fields
  localparam int MD_AUTOSW = 2;
  localparam int MD_SENSOR = 3;
  localparam int MD_DIRECT = 4;
  localparam int MD_CURMODE = 5;
  localparam logic [1:0] TES_POSITION = 2'h0;
  // current filter samples at a quarter of the peripheral clock
  localparam logic [1:0] QUARTER_LAST = 2'h3;
  // blanking step: 500 ns specified at a 4 mhz peripheral clock
  localparam int BLANK_STEP_NS = 500;
  localparam int BLANK_REF_MHZ = 4;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * BLANK_REF_MHZ + 999) / 1000;
endpackage

// file: rtl/sample_filter_if.sv
// one consecutive-sample filter channel
interface sample_filter_if;
  logic tick; // sample strobe
  logic sample; // condition met at this sample
  logic bypass; // one sample is enough
  logic clear; // soft reset of the filter
  logic [3:0] need; // code: samples needed minus one
  logic hit; // level, condition held long enough
  modport filt (input tick, sample, bypass, clear, need, output hit);
  modport user (output tick, sample, bypass, clear, need, input hit);
endinterface

// file: rtl/consecutive_filter.sv
module consecutive_filter (
  input wire logic clk, // peripheral clock
  input wire logic rst_n, // async reset, active low
  sample_filter_if.filt f // filter channel
);
  logic [3:0] cnt_q; // matching samples so far
  logic hit_q; // run long enough
  logic [3:0] cnt_d;
  logic hit_d;

  assign f.hit = hit_q;

  // count runs of matching samples
  always_comb begin
    cnt_d = cnt_q;
    hit_d = hit_q;
    if (f.clear) begin
      cnt_d = 4'h0;
      hit_d = 1'b0;
    end else if (f.tick) begin
      // RL23 restart on miss
      if (!f.sample) begin
        cnt_d = 4'h0;
        hit_d = 1'b0;
      end else if (f.bypass || cnt_q == f.need) begin
        // RL23 enough in a row
        hit_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end
endmodule

// file: sim/motor_phase_checker.sv
module motor_phase_checker import motor_phase_pkg::*; (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb strobes
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic hw_commutation, // hardware c source
  input wire logic sim_commutation, // simulated c source
  input wire logic [5:0] channel_on_bits, // switch enables
  input wire logic [1:0] comparator_input_select, // comparator route
  input wire logic encoder_mode, // encoder route
  input wire logic [2:0] reference_threshold_select, // reference code
  input wire logic external_reference_sel, // external reference
  input wire logic force_zero_off_time, // off time forced to zero
  input wire logic z_event, // z pulse
  input wire logic c_event, // c pulse
  input wire logic d_event, // d pulse
  input wire logic current_limit_event // current limit pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a whole-byte write completing at this edge
  wire wr_done = pready && pwrite && pstrb[0];
  // soft reset moves the channels without a c event
  wire srst_wr = wr_done && paddr == OFS_CURFB && pwdata[CF_SRST];
  enc_route_a: assert property (encoder_mode == (comparator_input_select == INSEL_ENCODER))
    else $error("encoder route mismatch");
  ext_ref_a: assert property (external_reference_sel == (reference_threshold_select == VREF_EXTERNAL))
    else $error("external reference mismatch");
  c_cause_a: assert property (c_event |-> $past(hw_commutation || sim_commutation || (wr_done && paddr == OFS_PHASE)))
    else $error("c event without a source");
  chan_at_c_a: assert property (!$stable(channel_on_bits) |-> c_event || $past(srst_wr))
    else $error("channels moved outside a c event");
  fast_off_a: assert property (wr_done && paddr == OFS_CTRL3 |=> force_zero_off_time == $past(pwdata[C3_FAST]))
    else $error("off time force does not follow fast bit");
  unmapped_err_a: assert property (pready && paddr > OFS_MODE |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  c_cov: cover property (c_event);
  z_cov: cover property (z_event);
  d_cov: cover property (d_event);
  cl_cov: cover property (current_limit_event);
endmodule

bind motor_phase_event_control motor_phase_checker i_motor_phase_checker (.*);

// file: sim/inverter_model.sv
// bridge and rotor sensors: periodic pwm marks, sampling strobe, quadrature encoder
module inverter_model (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic enc_on, // run the encoder
  input wire logic enc_fwd, // a leads b when set
  input wire logic [2:0] lvl, // current, demag, zero-cross comparator levels
  output logic scf_tick, // sampling strobe, every 4th clock
  output logic pwm_on_start, // pwm turn-on mark
  output logic pwm_off_end, // end of off time mark
  output logic position_input_a, // encoder a
  output logic position_input_b, // encoder b
  output logic position_input_c, // third pin, keeps moving
  output logic zero_cross_pin, // back-emf comparator
  output logic current_over_pin, // current comparator
  output logic demag_pin // demag comparator
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q; // pwm period of 16 clocks
  logic [1:0] ph_q; // quadrature step
  // one encoder step per pwm period, so edges stay far apart for the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      ph_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (enc_on && cnt_q == 4'hf) ph_q <= enc_fwd ? ph_q + 2'h1 : ph_q - 2'h1;
    end
  end
  assign scf_tick = cnt_q[1:0] == 2'h3;
  assign pwm_on_start = cnt_q == 4'h0;
  assign pwm_off_end = cnt_q == 4'h8;
  // gray order: counting up makes a change before b
  assign position_input_a = ph_q[1] ^ ph_q[0];
  assign position_input_b = ph_q[1];
  assign position_input_c = cnt_q[3];
  assign {current_over_pin, demag_pin, zero_cross_pin} = lvl;
endmodule

// file: sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import motor_phase_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, enc_on = 0, enc_fwd = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0;
  logic [4:0] pls = '0; // single-cycle request pulses
  logic [2:0] lvl = '0; // comparator levels for the model
  logic pready, pslverr, err, position_input_a, position_input_b, position_input_c;
  logic zero_cross_pin, current_over_pin, demag_pin, pwm_on_start, pwm_off_end, scf_tick;
  logic [5:0] channel_on_bits;
  logic [1:0] comparator_input_select;
  logic [2:0] reference_threshold_select;
  logic encoder_mode, external_reference_sel, force_zero_off_time;
  logic z_event, c_event, d_event, current_limit_event;
  wire sim_zero_cross, sim_commutation, hw_commutation, tacho_error, timer_overflow;
  int miscompares = 0, num_checks = 0, n_c = 0, n_z = 0, n_l = 0, n;
  assign {sim_zero_cross, sim_commutation, hw_commutation, tacho_error, timer_overflow} = pls;
  motor_phase_event_control #(.DWIN_STEP_TICKS(1)) i_motor_phase_event_control (.*);
  inverter_model i_inverter_model (.*);
  initial forever #20 pclk = ~pclk;
  // event tallies; read only at a later edge to avoid update races
  always @(posedge pclk) begin
    n_c <= n_c + int'(c_event === 1'b1);
    n_z <= n_z + int'(z_event === 1'b1);
    n_l <= n_l + int'(current_limit_event === 1'b1);
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic rng(input string s, input int lo, input int hi, input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("BAD %s exp %0d..%0d got %0d", s, lo, hi, g);
    end
  endtask
  // one apb transfer, entered and left at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'h1);
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(s, {24'h0, e}, rd);
  endtask
  task automatic pulse(input int i);
    pls[i] <= 1'b1;
    @(posedge pclk);
    pls[i] <= 1'b0;
    @(posedge pclk);
  endtask
  // edges (or strobes) until a current or d event shows
  task automatic span(input bit tk, output int c);
    int k;
    c = 0;
    for (k = 0; k < 300; k++) begin
      @(posedge pclk);
      c += tk ? int'(scf_tick === 1'b1) : 1;
      if (current_limit_event === 1'b1 || d_event === 1'b1) break;
    end
    if (k >= 300) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic t_regs();
    rdchk("ctrl3", OFS_CTRL3, CTRL3_RST);
    rdchk("phase", OFS_PHASE, PHASE_RST);
    rdchk("curfb", OFS_CURFB, CURFB_RST);
    rdchk("dfilt", OFS_DFILT, DFILT_RST);
    apb(1'b0, 8'h14, 32'h0, 4'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wr(OFS_CURFB, 8'h80);
    wr(OFS_DFILT, 8'h55);
    wr(OFS_CURFB, 8'h00);
    rdchk("page steer", OFS_DFILT, DFILT_RST);
    wr(OFS_DFILT, 8'h37);
    wr(OFS_PHASE, 8'h15);
    wr(OFS_CURFB, 8'h40);
    rdchk("srst dfilt", OFS_DFILT, DFILT_RST);
    rdchk("srst phase", OFS_PHASE, PHASE_RST);
    rdchk("srst curfb", OFS_CURFB, CURFB_RST);
    $display("regs done");
  endtask
  task automatic t_flag();
    wr(OFS_CTRL3, 8'hcf);
    rdchk("flag by write", OFS_CTRL3, 8'h4f);
    chk("ext ref", 32'h1, {31'h0, external_reference_sel});
    chk("zero off", 32'h1, {31'h0, force_zero_off_time});
    pulse(0);
    rdchk("ovf set", OFS_CTRL3, 8'hcf);
    wr(OFS_CTRL3, 8'h46);
    rdchk("flag clear", OFS_CTRL3, 8'h46);
    chk("int ref", 32'h0, {31'h0, external_reference_sel});
    wr(OFS_MODE, 8'h01);
    pulse(0);
    apb(1'b0, OFS_CTRL3, 32'h0, 4'h0);
    chk("ovf ignored", 32'h0, {31'h0, rd[7]});
    pulse(1);
    apb(1'b0, OFS_CTRL3, 32'h0, 4'h0);
    chk("tacho flag", 32'h1, {31'h0, rd[7]});
    enc_fwd <= 1'b1;
    enc_on <= 1'b1;
    repeat (80) @(posedge pclk);
    apb(1'b0, OFS_CTRL3, 32'h0, 4'h0);
    chk("a leads", 32'h1, {31'h0, rd[6]});
    enc_fwd <= 1'b0;
    repeat (80) @(posedge pclk);
    apb(1'b0, OFS_CTRL3, 32'h0, 4'h0);
    chk("a lags", 32'h0, {31'h0, rd[6]});
    enc_on <= 1'b0;
    wr(OFS_MODE, 8'h00);
    $display("flag done");
  endtask
  task automatic t_phase();
    wr(OFS_PHASE, 8'h85);
    chk("preload held", 32'h0, {26'h0, channel_on_bits});
    pulse(2);
    chk("chan at c", 32'h5, {26'h0, channel_on_bits});
    chk("insel", 32'h2, {30'h0, comparator_input_select});
    apb(1'b1, OFS_PHASE, 32'hff, 4'h0);
    pulse(2);
    chk("part strobe", 32'h5, {26'h0, channel_on_bits});
    wr(OFS_MODE, 8'h10);
    n = n_c;
    wr(OFS_PHASE, 8'he9);
    chk("direct chan", 32'h29, {26'h0, channel_on_bits});
    chk("encoder", 32'h1, {31'h0, encoder_mode});
    @(posedge pclk);
    chk("direct c", 32'h1, n_c - n);
    $display("phase done");
  endtask
  task automatic t_events();
    wr(OFS_MODE, 8'h04);
    wr(OFS_CTRL3, 8'h10);
    n = n_c;
    pulse(3);
    pulse(2);
    @(posedge pclk);
    chk("sim c", 32'h1, n_c - n);
    wr(OFS_CTRL3, 8'h20);
    n = n_c + n_z;
    pulse(3);
    pulse(2);
    pulse(4);
    @(posedge pclk);
    chk("hw c sim z", 32'h2, n_c + n_z - n);
    wr(OFS_CTRL3, 8'h40);
    lvl[0] <= 1'b1;
    n = n_z;
    repeat (40) @(posedge pclk);
    rng("z off end", 2, 3, n_z - n);
    wr(OFS_CTRL3, 8'h48);
    n = n_z;
    repeat (40) @(posedge pclk);
    rng("z fast", 9, 11, n_z - n);
    lvl[0] <= 1'b0;
    wr(OFS_CTRL3, 8'h00);
    wr(OFS_MODE, 8'h00);
    $display("events done");
  endtask
  task automatic t_filters();
    wr(OFS_CURFB, 8'h28);
    n = n_l;
    lvl[2] <= 1'b1;
    repeat (12) @(posedge pclk);
    lvl[2] <= 1'b0;
    repeat (40) @(posedge pclk);
    chk("short run", 32'h0, n_l - n);
    lvl[2] <= 1'b1;
    span(1'b0, n);
    rng("cur samples", 25, 31, n);
    lvl[2] <= 1'b0;
    wr(OFS_DFILT, 8'h30);
    lvl[1] <= 1'b1;
    span(1'b1, n);
    rng("d samples", 4, 6, n);
    lvl[1] <= 1'b0;
    wr(OFS_MODE, 8'h08);
    repeat (12) @(posedge pclk);
    lvl[1] <= 1'b1;
    span(1'b1, n);
    rng("sensor d", 1, 3, n);
    $display("filters done");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_flag();
    t_phase();
    t_events();
    t_filters();
    conclude();
  end
endmodule
